//--- rtl/motor_pwm_time_base_control.sv
// time base, special event trigger and global control of a four-pair pwm
// assumes cpu_idle and pin_reset_config come from logic on clk
`timescale 1ns/1ps
module motor_pwm_time_base_control (
   input wire logic clk,                         // 125 mhz clock
   input wire logic rstn,                        // async reset, active low
   input wire logic psel,                        // apb select
   input wire logic penable,                     // apb access phase
   input wire logic pwrite,                      // apb write
   input wire logic [7:0] paddr,                 // apb byte address
   input wire logic [31:0] pwdata,               // apb write data
   output logic [31:0] prdata,                   // apb read data
   output logic pready,                          // apb ready
   output logic pslverr,                         // apb error on unmapped
   input wire logic cpu_idle,                    // cpu in idle mode
   input wire logic pin_reset_config,            // config word pin bit
   output logic [14:0] active_period,            // period in use
   output pwm_tb_pkg::tb_hooks_s hooks,          // time base events
   output pwm_tb_pkg::pin_ctrl_s pins            // pad control
);

   // software registers
   logic timer_on_reg;
   logic stop_in_idle_reg;
   logic [3:0] period_post_sel_reg;
   logic [1:0] prescale_sel_reg;
   logic [1:0] scheme_reg;
   logic [14:0] count_reg;
   logic count_down_reg;
   logic [14:0] period_buf_reg;
   logic trig_dir_reg;
   logic [14:0] trig_cmp_reg;
   logic [3:0] pair_indep_reg;
   logic [3:0] high_en_reg;
   logic [3:0] low_en_reg;
   logic [3:0] trig_post_sel_reg;
   logic immediate_reg;
   logic override_sync_reg;
   logic update_disable_reg;
   // internal state
   logic strap_done_reg;
   logic tristate_reg;
   logic [5:0] presc_cnt_reg;
   logic [3:0] period_post_cnt_reg;
   logic [3:0] trig_post_cnt_reg;
   logic advanced_reg;
   logic [14:0] active_period_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic period_event_reg;
   logic trigger_event_reg;
   logic duty_load_reg;
   logic override_apply_reg;

   // tick period limit for a prescale code
   function automatic logic [5:0] presc_limit(input logic [1:0] sel);
      logic [5:0] lim;
      lim = pwm_tb_pkg::presc_lim_1;
      case (sel)
         2'h1: lim = pwm_tb_pkg::presc_lim_4;
         2'h2: lim = pwm_tb_pkg::presc_lim_16;
         2'h3: lim = pwm_tb_pkg::presc_lim_64;
         default: lim = pwm_tb_pkg::presc_lim_1;
      endcase
      return lim;
   endfunction : presc_limit

   // address decode, used by the error flag only; the read mux compares paddr by itself
   function automatic logic addr_mapped(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      if (a == pwm_tb_pkg::ctrl_off) begin
         hit = 1'b1;
      end else if (a == pwm_tb_pkg::count_off) begin
         hit = 1'b1;
      end else if (a == pwm_tb_pkg::period_off) begin
         hit = 1'b1;
      end else if (a == pwm_tb_pkg::compare_off) begin
         hit = 1'b1;
      end else if (a == pwm_tb_pkg::pairpin_off) begin
         hit = 1'b1;
      end else if (a == pwm_tb_pkg::update_off) begin
         hit = 1'b1;
      end
      return hit;
   endfunction : addr_mapped

   // bus strobes
   logic wr_en;
   logic setup_ph;
   assign setup_ph = psel & ~penable;
   assign wr_en = psel & penable & pready_reg & pwrite;

   logic wr_ctrl;
   logic wr_count;
   logic wr_period;
   logic wr_compare;
   logic wr_pairpin;
   logic wr_update;
   assign wr_ctrl = wr_en & (paddr == pwm_tb_pkg::ctrl_off);
   assign wr_count = wr_en & (paddr == pwm_tb_pkg::count_off);
   assign wr_period = wr_en & (paddr == pwm_tb_pkg::period_off);
   assign wr_compare = wr_en & (paddr == pwm_tb_pkg::compare_off);
   assign wr_pairpin = wr_en & (paddr == pwm_tb_pkg::pairpin_off);
   assign wr_update = wr_en & (paddr == pwm_tb_pkg::update_off);

   // run gating and prescaled tick
   logic running;
   logic tick;
   logic updown;
   assign running = timer_on_reg & ~(stop_in_idle_reg & cpu_idle);
   assign tick = running & (presc_cnt_reg == presc_limit(prescale_sel_reg));
   assign updown = scheme_reg[1];

   // count step decisions
   localparam logic [14:0] count_reset_c = pwm_tb_pkg::count_reset;
   logic at_top;
   logic at_zero;
   logic cycle_start;
   logic half_point;
   assign at_top = (count_reg >= active_period_reg);
   assign at_zero = (count_reg == count_reset_c);
   // a new pwm cycle starts on the wrap in edge mode, at zero in up/down
   assign cycle_start = tick & (updown ? (count_down_reg & at_zero) : at_top);
   assign half_point = tick & updown & ~count_down_reg & at_top;

   // prescaler counter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         presc_cnt_reg <= 6'h00;
      end else if (!running || tick || wr_count) begin
         presc_cnt_reg <= 6'h00; // restart so a written count gets a full tick
      end else begin
         presc_cnt_reg <= presc_cnt_reg + 6'h01;
      end
   end

   // time_base_control register; single pulse end clears timer_on
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         timer_on_reg <= 1'b0;
         stop_in_idle_reg <= 1'b0;
         period_post_sel_reg <= 4'h0;
         prescale_sel_reg <= 2'h0;
         scheme_reg <= pwm_tb_pkg::scheme_free;
      end else if (wr_ctrl) begin
         timer_on_reg <= pwdata[pwm_tb_pkg::timer_on_pos];
         stop_in_idle_reg <= pwdata[pwm_tb_pkg::stop_in_idle_pos];
         period_post_sel_reg <= pwdata[pwm_tb_pkg::period_post_lsb +: 4];
         prescale_sel_reg <= pwdata[pwm_tb_pkg::prescale_lsb +: 2];
         scheme_reg <= pwdata[pwm_tb_pkg::scheme_lsb +: 2];
      end else if (scheme_reg == pwm_tb_pkg::scheme_single && tick && at_top) begin
         timer_on_reg <= 1'b0;
      end
   end

   // counter and direction; a software write of the count wins over a tick
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= pwm_tb_pkg::count_reset;
         count_down_reg <= 1'b0;
      end else if (wr_count) begin
         count_reg <= pwdata[14:0];
      end else if (!timer_on_reg && !updown) begin
         count_down_reg <= 1'b0;
      end else if (tick) begin
         if (!updown) begin
            count_down_reg <= 1'b0;
            count_reg <= at_top ? count_reset_c : count_reg + 15'h0001;
         end else if (!count_down_reg) begin
            if (at_top) begin
               count_down_reg <= 1'b1;
               count_reg <= at_zero ? count_reset_c : count_reg - 15'h0001;
            end else begin
               count_reg <= count_reg + 15'h0001;
            end
         end else if (at_zero) begin
            count_down_reg <= 1'b0;
            count_reg <= (active_period_reg == count_reset_c) ? count_reset_c :
                         count_reg + 15'h0001;
         end else begin
            count_reg <= count_reg - 15'h0001;
         end
      end
   end

   // period buffer and active period; with update_disable_reg clear, transfer at cycle start or while timer_on is clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         period_buf_reg <= 15'h0000;
         active_period_reg <= 15'h0000;
      end else begin
         if (wr_period) begin
            period_buf_reg <= pwdata[14:0];
         end
         // immediate_update plays no part here
         if (!update_disable_reg && (cycle_start || !timer_on_reg)) begin
            active_period_reg <= period_buf_reg;
         end
      end
   end

   // special event compare register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         trig_dir_reg <= 1'b0;
         trig_cmp_reg <= 15'h0000;
      end else if (wr_compare) begin
         trig_dir_reg <= pwdata[pwm_tb_pkg::dir_pos];
         trig_cmp_reg <= pwdata[14:0];
      end
   end

   // flag that the count moved last cycle, so a match fires once per value
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         advanced_reg <= 1'b0;
      end else begin
         advanced_reg <= tick | wr_count;
      end
   end

   logic trig_raw;
   assign trig_raw = advanced_reg & (count_reg == trig_cmp_reg) &
                     (~updown | (trig_dir_reg == count_down_reg));

   // special event postscaler
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         trig_post_cnt_reg <= 4'h0;
         trigger_event_reg <= 1'b0;
      end else if (wr_compare) begin
         trig_post_cnt_reg <= 4'h0;
         trigger_event_reg <= 1'b0;
      end else if (trig_raw) begin
         if (trig_post_cnt_reg >= trig_post_sel_reg) begin
            trig_post_cnt_reg <= 4'h0;
            trigger_event_reg <= 1'b1;
         end else begin
            trig_post_cnt_reg <= trig_post_cnt_reg + 4'h1;
            trigger_event_reg <= 1'b0;
         end
      end else begin
         trigger_event_reg <= 1'b0;
      end
   end

   // period postscaler, counts cycle starts
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         period_post_cnt_reg <= 4'h0;
         period_event_reg <= 1'b0;
      end else if (cycle_start) begin
         if (period_post_cnt_reg >= period_post_sel_reg) begin
            period_post_cnt_reg <= 4'h0;
            period_event_reg <= 1'b1;
         end else begin
            period_post_cnt_reg <= period_post_cnt_reg + 4'h1;
            period_event_reg <= 1'b0;
         end
      end else begin
         period_event_reg <= 1'b0;
      end
   end

   // duty transfer and override timing hooks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         duty_load_reg <= 1'b0;
         override_apply_reg <= 1'b0;
      end else begin
         // double update scheme also reloads at the period turn
         duty_load_reg <= ~update_disable_reg & (cycle_start |
                          (half_point & (scheme_reg == pwm_tb_pkg::scheme_updown_dbl)));
         override_apply_reg <= override_sync_reg ?
                               (cycle_start | half_point) : 1'b1;
      end
   end

   // pair mode and pin enables; enables settle one edge after reset release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pair_indep_reg <= 4'h0;
         high_en_reg <= 4'h0;
         low_en_reg <= 4'h0;
         strap_done_reg <= 1'b0;
         tristate_reg <= 1'b1;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         high_en_reg <= {4{~pin_reset_config}};
         low_en_reg <= {4{~pin_reset_config}};
         tristate_reg <= pin_reset_config;
      end else if (wr_pairpin) begin
         pair_indep_reg <= pwdata[pwm_tb_pkg::pair_lsb +: 4];
         high_en_reg <= pwdata[pwm_tb_pkg::high_en_lsb +: 4];
         low_en_reg <= pwdata[pwm_tb_pkg::low_en_lsb +: 4];
         tristate_reg <= 1'b0;
      end
   end

   // update and trigger control register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         trig_post_sel_reg <= 4'h0;
         immediate_reg <= 1'b0;
         override_sync_reg <= 1'b0;
         update_disable_reg <= 1'b0;
      end else if (wr_update) begin
         trig_post_sel_reg <= pwdata[pwm_tb_pkg::trig_post_lsb +: 4];
         immediate_reg <= pwdata[pwm_tb_pkg::immediate_pos];
         override_sync_reg <= pwdata[pwm_tb_pkg::override_sync_pos];
         update_disable_reg <= pwdata[pwm_tb_pkg::update_disable_pos];
      end
   end

   // read mux; unimplemented bits stay zero
   logic [15:0] rd_word;
   always_comb begin
      rd_word = pwm_tb_pkg::reg_reset;
      if (paddr == pwm_tb_pkg::ctrl_off) begin
         rd_word[pwm_tb_pkg::timer_on_pos] = timer_on_reg;
         rd_word[pwm_tb_pkg::stop_in_idle_pos] = stop_in_idle_reg;
         rd_word[pwm_tb_pkg::period_post_lsb +: 4] = period_post_sel_reg;
         rd_word[pwm_tb_pkg::prescale_lsb +: 2] = prescale_sel_reg;
         rd_word[pwm_tb_pkg::scheme_lsb +: 2] = scheme_reg;
      end else if (paddr == pwm_tb_pkg::count_off) begin
         rd_word = {count_down_reg, count_reg};
      end else if (paddr == pwm_tb_pkg::period_off) begin
         rd_word = {1'b0, period_buf_reg};
      end else if (paddr == pwm_tb_pkg::compare_off) begin
         rd_word = {trig_dir_reg, trig_cmp_reg};
      end else if (paddr == pwm_tb_pkg::pairpin_off) begin
         rd_word[pwm_tb_pkg::pair_lsb +: 4] = pair_indep_reg;
         rd_word[pwm_tb_pkg::high_en_lsb +: 4] = high_en_reg;
         rd_word[pwm_tb_pkg::low_en_lsb +: 4] = low_en_reg;
      end else if (paddr == pwm_tb_pkg::update_off) begin
         rd_word[pwm_tb_pkg::trig_post_lsb +: 4] = trig_post_sel_reg;
         rd_word[pwm_tb_pkg::immediate_pos] = immediate_reg;
         rd_word[pwm_tb_pkg::override_sync_pos] = override_sync_reg;
         rd_word[pwm_tb_pkg::update_disable_pos] = update_disable_reg;
      end
   end

   // apb answer: data captured in setup, ready in the first access cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= setup_ph;
         pslverr_reg <= setup_ph & ~addr_mapped(paddr);
         if (setup_ph && !pwrite) begin
            prdata_reg <= {16'h0000, rd_word};
         end
      end
   end

   // outputs, all from flops
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign active_period = active_period_reg;
   assign hooks.period_event = period_event_reg;
   assign hooks.trigger_event = trigger_event_reg;
   assign hooks.duty_load = duty_load_reg;
   assign hooks.duty_immediate = immediate_reg;
   assign hooks.override_apply = override_apply_reg;
   assign hooks.count_down = count_down_reg;
   assign pins.pair_independent = pair_indep_reg;
   assign pins.high_enable = high_en_reg;
   assign pins.low_enable = low_en_reg;
   assign pins.pins_tristate = tristate_reg;

endmodule : motor_pwm_time_base_control

//--- rtl/pwm_tb_pkg.sv
// constants, field layout and carriers for the motor pwm time base block
// assumes an apb master on clk and a pin/duty/override stage fed by the hooks
package pwm_tb_pkg;
   // register byte offsets on the apb
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] count_off = 8'h04;
   localparam logic [7:0] period_off = 8'h08;
   localparam logic [7:0] compare_off = 8'h0c;
   localparam logic [7:0] pairpin_off = 8'h10;
   localparam logic [7:0] update_off = 8'h14;
   // time_base_control field positions
   localparam int timer_on_pos = 15;
   localparam int stop_in_idle_pos = 13;
   localparam int period_post_lsb = 4;
   localparam int prescale_lsb = 2;
   localparam int scheme_lsb = 0;
   // shared top-bit position for direction flags
   localparam int dir_pos = 15;
   // pair_mode_and_pin_enable fields
   localparam int pair_lsb = 8;
   localparam int high_en_lsb = 4;
   localparam int low_en_lsb = 0;
   // update_and_trigger_control fields
   localparam int trig_post_lsb = 8;
   localparam int immediate_pos = 2;
   localparam int override_sync_pos = 1;
   localparam int update_disable_pos = 0;
   // count schemes
   localparam logic [1:0] scheme_free = 2'h0;
   localparam logic [1:0] scheme_single = 2'h1;
   localparam logic [1:0] scheme_updown = 2'h2;
   localparam logic [1:0] scheme_updown_dbl = 2'h3;
   // prescale tick limits, in cycles minus one
   localparam logic [5:0] presc_lim_1 = 6'h00;
   localparam logic [5:0] presc_lim_4 = 6'h03;
   localparam logic [5:0] presc_lim_16 = 6'h0f;
   localparam logic [5:0] presc_lim_64 = 6'h3f;
   // reset values
   localparam logic [15:0] reg_reset = 16'h0000;
   localparam logic [14:0] count_reset = 15'h0000;

   // time base events toward the pwm output stage
   typedef struct packed {
      logic period_event;   // postscaled period pulse
      logic trigger_event;  // postscaled special event pulse
      logic duty_load;      // duty buffer to active transfer pulse
      logic duty_immediate; // duty writes act at once
      logic override_apply; // apply manual overrides now
      logic count_down;     // current count direction
   } tb_hooks_s;

   // pin control toward the output pads
   typedef struct packed {
      logic [3:0] pair_independent; // per pair independent mode
      logic [3:0] high_enable;      // high pin owned by pwm
      logic [3:0] low_enable;       // low pin owned by pwm
      logic pins_tristate;          // pads released after reset when pin_reset_config is set, until the first pin write
   } pin_ctrl_s;
endpackage : pwm_tb_pkg

//--- test/motor_pwm_time_base_control_asserts.sv
// checker for the pwm time base block, bound to its ports
// assumes one clock domain and an apb master that never stalls setup
`timescale 1ns/1ps
module motor_pwm_asserts (
   input wire logic clk,                // clock
   input wire logic rstn,               // reset, active low
   input wire logic psel,               // apb select
   input wire logic penable,            // apb access
   input wire logic pwrite,             // apb write
   input wire logic [7:0] paddr,        // apb address
   input wire logic [31:0] pwdata,      // apb write data
   input wire logic [31:0] prdata,      // apb read data
   input wire logic pready,             // apb ready
   input wire logic pslverr,            // apb error
   input wire logic cpu_idle,           // cpu idle
   input wire logic pin_reset_config,   // pad reset choice
   input wire logic [14:0] active_period, // period in use
   input wire pwm_tb_pkg::tb_hooks_s hooks, // time base events
   input wire pwm_tb_pkg::pin_ctrl_s pins   // pad control
);
   // completed transfers only, so setup cycles never count
   wire logic acc = psel && penable && pready;
   wire logic rd = acc && !pwrite;
   wire logic wr = acc && pwrite;
   wire logic wr_upd = wr && paddr == pwm_tb_pkg::update_off;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   chk_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not one access cycle");
   chk_err_decode: assert property (acc |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0))
      else $error("pslverr decode wrong");
   chk_bad_read: assert property (rd && pslverr |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   chk_period_top: assert property (rd && paddr == pwm_tb_pkg::period_off |-> !prdata[15])
      else $error("period top bit set");
   chk_ctrl_gaps: assert property (rd && paddr == pwm_tb_pkg::ctrl_off |->
      prdata[31:16] == 16'h0 && !prdata[14] && prdata[12:8] == 5'h00)
      else $error("control gap bits set");
   chk_upd_gaps: assert property (rd && paddr == pwm_tb_pkg::update_off |->
      prdata[15:12] == 4'h0 && prdata[7:3] == 5'h00)
      else $error("update gap bits set");
   chk_pin_reset: assert property ($rose(rstn) |=> pins.high_enable == {4{~$past(pin_reset_config)}}
      && pins.low_enable == {4{~$past(pin_reset_config)}} && pins.pins_tristate == $past(pin_reset_config))
      else $error("pin enables wrong after reset");
   chk_pin_write: assert property (wr && paddr == pwm_tb_pkg::pairpin_off |=> !pins.pins_tristate
      && {pins.pair_independent, pins.high_enable, pins.low_enable} == $past(pwdata[11:0]))
      else $error("pin register write not applied");
   chk_imm_follow: assert property (wr_upd |-> ##2 hooks.duty_immediate == $past(pwdata[2], 2))
      else $error("duty_immediate not following bit");
   chk_ovr_free: assert property (wr_upd && !pwdata[1] |-> ##2 hooks.override_apply [*2])
      else $error("override not applied every cycle");
   // read data was captured at setup, so compare against the flag of that cycle
   chk_dir_read: assert property (rd && paddr == pwm_tb_pkg::count_off |->
      prdata[15] == $past(hooks.count_down))
      else $error("count direction bit wrong");
   cover property (hooks.period_event);
   cover property (hooks.trigger_event);
   cover property (acc && pslverr);
endmodule : motor_pwm_asserts

bind motor_pwm_time_base_control motor_pwm_asserts motor_pwm_asserts_i (.clk(clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle),
   .pin_reset_config(pin_reset_config), .active_period(active_period), .hooks(hooks), .pins(pins));

//--- test/switch_model.sv
// partner: the power switches hanging on the pwm pads
// assumes pin control comes straight from the block, same clock
`timescale 1ns/1ps
module switch_model (
   input wire pwm_tb_pkg::pin_ctrl_s pins, // pad control from the block
   output logic [3:0] owned_h,             // high switches fed by pwm
   output logic [3:0] owned_l              // low switches fed by pwm
);
   // a released pad drives no switch, so gpio takeover shows as zero
   assign owned_h = pins.high_enable & {4{~pins.pins_tristate}};
   assign owned_l = pins.low_enable & {4{~pins.pins_tristate}};
endmodule : switch_model

//--- test/tb_motor_pwm_time_base_control.sv
// self-checking bench for the pwm time base block
// assumes the block answers apb with one access cycle, as handed over
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fail_count++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module tb_motor_pwm_time_base_control;
   logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, cpu_idle = 0, pin_reset_config = 1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, e;
   logic pready, pslverr;
   logic [14:0] active_period;
   pwm_tb_pkg::tb_hooks_s hooks;
   pwm_tb_pkg::pin_ctrl_s pins;
   logic [3:0] owned_h, owned_l;
   logic [31:0] q[$];
   logic [15:0] r = 16'h0012;
   int fail_count = 0, n_tests = 0, cyc = 0, n, m;
   logic [7:0] ra[4] = '{pwm_tb_pkg::period_off, pwm_tb_pkg::compare_off,
      pwm_tb_pkg::pairpin_off, pwm_tb_pkg::update_off};
   logic [15:0] rm[4] = '{16'h7fff, 16'hffff, 16'h0fff, 16'h0f07};
   // control words and the period gap each must give with period 2
   logic [15:0] tc[6] = '{16'h8000, 16'h8054, 16'h80a8, 16'h80fc, 16'h8002, 16'h8013};
   int ts[6] = '{3, 72, 528, 3072, 4, 8};
   motor_pwm_time_base_control motor_pwm_time_base_control_i (.clk(clk), .rstn(rstn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle),
      .pin_reset_config(pin_reset_config), .active_period(active_period), .hooks(hooks),
      .pins(pins));
   switch_model switch_model_i (.pins(pins), .owned_h(owned_h), .owned_l(owned_l));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // one apb transfer; on a read d is the expected word, noted for the monitor
   task xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      if (!w) q.push_back({16'h0000, d});
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : xfer
   // cycles until the chosen event pulses, bounded
   task ev(input bit w, output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while ((w ? hooks.trigger_event : hooks.period_event) !== 1'b1 && k < 9000);
   endtask : ev
   task rst(input logic p);
      pin_reset_config <= p;
      rstn <= 1'b0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : rst
   initial forever #4 clk = ~clk;
   // hang guard, well above the longest postscaled gaps
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         wrap_up();
      end
   end
   // read data is taken at the edge where pready is sampled high
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         e = q.pop_front();
         `CHK("prdata", e, prdata)
      end
   end
   initial begin
      for (int p = 1; p >= 0; p--) begin
         rst(p[0]);
         xfer(1'b0, pwm_tb_pkg::pairpin_off, p ? 16'h0000 : 16'h00ff);
      end
      xfer(1'b0, pwm_tb_pkg::ctrl_off, 16'h0000);
      xfer(1'b0, pwm_tb_pkg::count_off, 16'h0000);
      // the last reset had pin_reset_config low, so every pin enable came up set
      foreach (ra[i]) xfer(1'b0, ra[i], (ra[i] == pwm_tb_pkg::pairpin_off) ? 16'h00ff : 16'h0000);
      xfer(1'b1, 8'h18, 16'hffff);
      xfer(1'b0, 8'h18, 16'h0000);
      $display("test reset done");
      repeat (3) foreach (ra[i]) begin
         r = lfsr(r);
         xfer(1'b1, ra[i], r);
         xfer(1'b0, ra[i], r & rm[i]);
      end
      r = lfsr(r);
      xfer(1'b1, pwm_tb_pkg::ctrl_off, r & 16'h7fff);
      xfer(1'b0, pwm_tb_pkg::ctrl_off, r & 16'h20ff);
      $display("test registers done");
      xfer(1'b1, pwm_tb_pkg::ctrl_off, 16'h0000);
      xfer(1'b1, pwm_tb_pkg::update_off, 16'h0000);
      xfer(1'b1, pwm_tb_pkg::count_off, 16'h8005);
      repeat (10) @(posedge clk);
      xfer(1'b0, pwm_tb_pkg::count_off, 16'h0005);
      xfer(1'b1, pwm_tb_pkg::period_off, 16'd100);
      xfer(1'b1, pwm_tb_pkg::count_off, 16'd10);
      cpu_idle <= 1'b1;
      xfer(1'b1, pwm_tb_pkg::ctrl_off, 16'ha000);
      repeat (20) @(posedge clk);
      xfer(1'b0, pwm_tb_pkg::count_off, 16'd10);
      // idle stays high here: with stop_in_idle clear the base must run
      xfer(1'b1, pwm_tb_pkg::ctrl_off, 16'h0000);
      xfer(1'b1, pwm_tb_pkg::period_off, 16'd2);
      for (int i = 0; i < 6; i++) begin
         xfer(1'b1, pwm_tb_pkg::ctrl_off, tc[i]);
         ev(1'b0, n);
         ev(1'b0, n);
         `CHK("period gap", ts[i], n)
      end
      cpu_idle <= 1'b0;
      $display("test time base done");
      xfer(1'b1, pwm_tb_pkg::ctrl_off, 16'h0000);
      xfer(1'b1, pwm_tb_pkg::period_off, 16'd4);
      xfer(1'b1, pwm_tb_pkg::compare_off, 16'h0003);
      xfer(1'b1, pwm_tb_pkg::ctrl_off, 16'h8002);
      ev(1'b0, n);
      ev(1'b1, n);
      xfer(1'b1, pwm_tb_pkg::compare_off, 16'h8003);
      ev(1'b0, m);
      ev(1'b1, m);
      `CHK("direction", 1'b1, hooks.count_down)
      `CHK("trigger phase", 2, m - n)
      xfer(1'b1, pwm_tb_pkg::ctrl_off, 16'h8000);
      ev(1'b1, n);
      ev(1'b1, n);
      `CHK("trigger free", 5, n)
      xfer(1'b1, pwm_tb_pkg::update_off, 16'h0200);
      ev(1'b1, n);
      ev(1'b1, n);
      `CHK("trigger post", 15, n)
      // lockout is clear, so every cycle start also opens a duty transfer
      ev(1'b0, n);
      `CHK("duty load", 1'b1, hooks.duty_load)
      $display("test trigger done");
      xfer(1'b1, pwm_tb_pkg::ctrl_off, 16'h0000);
      xfer(1'b1, pwm_tb_pkg::period_off, 16'd9);
      repeat (3) @(posedge clk);
      `CHK("period", 15'h0009, active_period)
      xfer(1'b1, pwm_tb_pkg::update_off, 16'h0005);
      xfer(1'b1, pwm_tb_pkg::period_off, 16'd5);
      repeat (3) @(posedge clk);
      `CHK("period locked", 15'h0009, active_period)
      xfer(1'b1, pwm_tb_pkg::update_off, 16'h0000);
      repeat (3) @(posedge clk);
      `CHK("period freed", 15'h0005, active_period)
      xfer(1'b1, pwm_tb_pkg::period_off, 16'd3);
      xfer(1'b1, pwm_tb_pkg::ctrl_off, 16'h8001);
      repeat (20) @(posedge clk);
      xfer(1'b0, pwm_tb_pkg::ctrl_off, 16'h0001);
      xfer(1'b0, pwm_tb_pkg::count_off, 16'h0000);
      xfer(1'b1, pwm_tb_pkg::pairpin_off, 16'h0a5c);
      repeat (2) @(posedge clk);
      `CHK("pairs", 4'ha, pins.pair_independent)
      `CHK("high owned", 4'h5, owned_h)
      `CHK("low owned", 4'hc, owned_l)
      $display("test control done");
      wrap_up();
   end
endmodule : tb_motor_pwm_time_base_control
